// [verilog/tts_sequencer.sv]
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - A measurement starts only on a rising trigger input from the controller.
// - Each accepted trigger with a nonzero pulse count yields exactly one pulse on the start output.
// - The transmit burst begins on the same cycle the start pulse rises.
// - Transmit clock is the reference clock divided by a power of two only.
// - Transmit frequency is reference over two to the (divide select plus one).
// - Exactly the configured number of transmit pulses per burst.
// - Start lasts one transmit period per pulse, at most three periods.
// - Optional 180 degree phase inversion from a chosen pulse position onward.
// - Optional damping of the final burst pulse.
// - One of three profiles must be selected before measurements run.
// - Qualified echo zero crossings drive pulses on the stop output.
// - Zero-cross level rises above reference, falls only below reference minus hysteresis.
module tts_sequencer
    import tts_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Controller pins
    input  wire logic        enable_i,
    input  wire logic        trigger_i,
    input  wire logic        reference_clock_input_i,
    // Comparator results on the comparator_input node
    input  wire logic        echo_above_ref_i,
    input  wire logic        echo_below_hyst_i,
    input  wire logic        echo_over_thld_i,
    // Transducer and timing outputs
    output logic             tx_p_o,
    output logic             tx_n_o,
    output logic             tx_damp_o,
    output logic             start_o,
    output logic             stop_o,
    output logic             busy_o
);

    import tts_pkg::*;

    localparam int NPIN = 6;
    localparam int PCW  = 9;

    logic             rst_s1_r;
    logic             rst_n_r;
    logic [NPIN-1:0]  pin_lvl;
    logic             en_lvl;
    logic             trig_lvl;
    logic             ref_lvl;
    logic             above_lvl;
    logic             below_lvl;
    logic             thld_lvl;
    logic             trig_d_r;
    logic             ref_d_r;
    logic             ref_edge;
    logic             trig_edge;
    logic             trig_ok;
    logic             pend_r;
    logic [31:0]      cfg_word_r;
    tts_cfg_t         cfg;
    tts_cfg_t         run_r;
    tts_state_t       state_r;
    tts_state_t       state_nxt;
    logic [PCW-1:0]   per_cnt_r;
    logic [PCW-1:0]   per_last;
    logic [PCW-1:0]   half;
    logic             per_wrap;
    logic [TTS_NUM_W-1:0] pulse_r;
    logic [TTS_WIN_W-1:0] win_r;
    logic             zc_r;
    logic             zc_d_r;
    logic             qual_r;
    logic [7:0]       stops_r;
    logic [7:0]       runs_r;
    logic             bus_req;
    logic             wr_cfg;
    logic             tx_p_nxt;
    logic             start_nxt;
    logic             last_pulse;
    logic [TTS_NUM_W-1:0] start_len;

    // Byte-lane merge used by the configuration write path
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_lanes

    // Field split of the configuration word; shared by the live view and the reset value
    function automatic tts_cfg_t cfg_decode(input logic [31:0] w);
        return tts_cfg_t'({w[TTS_WIN_LSB +: TTS_WIN_W], w[TTS_PROF_LSB +: TTS_PROF_W], w[TTS_DAMP_BIT],
                           w[TTS_SHEN_BIT], w[TTS_SHPOS_LSB +: TTS_NUM_W], w[TTS_NUM_LSB +: TTS_NUM_W],
                           w[TTS_DIV_LSB +: TTS_DIV_W]});
    endfunction : cfg_decode

    // Reset release through two flops; the assert stays asynchronous
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // All pins come from outside the clock domain
    tts_pin_sync #(
        .W (NPIN)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_r),
        .pin_i   ({echo_over_thld_i, echo_below_hyst_i, echo_above_ref_i,
                   reference_clock_input_i, trigger_i, enable_i}),
        .level_o (pin_lvl)
    );

    assign {thld_lvl, below_lvl, above_lvl, ref_lvl, trig_lvl, en_lvl} = pin_lvl;

    // Edge detection on the filtered levels
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            trig_d_r <= 1'b0;
            ref_d_r  <= 1'b0;
        end else begin
            trig_d_r <= trig_lvl;
            ref_d_r  <= ref_lvl;
        end
    end

    assign ref_edge  = ref_lvl & ~ref_d_r;
    assign trig_edge = trig_lvl & ~trig_d_r;

    // Wishbone decode; one wait state keeps the answer registered
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_cfg  = bus_req & wb_we_i & (wb_adr_i == TTS_CFG_OFS);
    assign cfg     = cfg_decode(cfg_word_r);

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Configuration register; takes effect at the next trigger
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_word_r <= TTS_CFG_RST;
        end else if (wr_cfg) begin
            cfg_word_r <= merge_lanes(cfg_word_r, wb_dat_i, wb_sel_i);
        end
    end

    // Read data; unmapped offsets answer with zero
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                TTS_CFG_OFS: begin
                    wb_dat_o <= cfg_word_r;
                end
                TTS_STAT_OFS: begin
                    wb_dat_o <= 32'h0000_0000;
                    wb_dat_o[TTS_ST_BUSY_BIT]        <= (state_r != TTS_IDLE);
                    wb_dat_o[TTS_ST_ZC_BIT]          <= zc_r;
                    wb_dat_o[TTS_ST_QUAL_BIT]        <= qual_r;
                    wb_dat_o[TTS_ST_STOPS_LSB +: 8]  <= stops_r;
                    wb_dat_o[TTS_ST_RUNS_LSB +: 8]   <= runs_r;
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Period arithmetic; half and full periods are powers of two only
    assign half     = PCW'(1) << run_r.tx_divide_select;
    assign per_last = PCW'((PCW'(1) << ({1'b0, run_r.tx_divide_select} + 4'h1)) - PCW'(1));
    assign per_wrap = ref_edge & (per_cnt_r == per_last);
    assign last_pulse = (pulse_r == run_r.pulse_count - 5'h01);
    // Profile 3 is not a valid selection, so no run starts
    assign trig_ok = (state_r == TTS_IDLE) & trig_edge & en_lvl & (cfg.profile != TTS_PROF_NONE);

    // Trigger waits for a reference edge so the first half period is full length
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= (trig_ok | pend_r) & ~ref_edge & en_lvl;
        end
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TTS_IDLE: begin
                if ((trig_ok || pend_r) && ref_edge) begin
                    state_nxt = (cfg.pulse_count == '0) ? TTS_RX : TTS_TX;
                end
            end
            TTS_TX: begin
                if (per_wrap && last_pulse) begin
                    state_nxt = TTS_RX;
                end
            end
            TTS_RX: begin
                if (per_wrap && win_r == '0) begin
                    state_nxt = TTS_IDLE;
                end
            end
            default: begin
                state_nxt = TTS_IDLE;
            end
        endcase
        if (!en_lvl) begin
            state_nxt = TTS_IDLE;
        end
    end

    // State register; triggers in TX or RX have no effect
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= TTS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Configuration snapshot so a write mid-run cannot warp the burst
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            run_r <= cfg_decode(TTS_CFG_RST);
        end else if (state_r == TTS_IDLE) begin
            run_r <= cfg;
        end
    end

    // Reference-edge period counter and pulse index
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            per_cnt_r <= '0;
            pulse_r   <= '0;
        end else if (state_r == TTS_IDLE || state_nxt != state_r) begin
            per_cnt_r <= '0;
            pulse_r   <= '0;
        end else if (per_wrap) begin
            per_cnt_r <= '0;
            pulse_r   <= pulse_r + 5'h01;
        end else if (ref_edge) begin
            per_cnt_r <= per_cnt_r + PCW'(1);
        end
    end

    // Receive window in transmit periods
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            win_r <= '0;
        end else if (state_r != TTS_RX) begin
            win_r <= run_r.rx_window;
        end else if (per_wrap && win_r != '0) begin
            win_r <= win_r - 8'h01;
        end
    end

    // Start length is pulse count capped at three periods
    assign start_len = (run_r.pulse_count > TTS_START_CAP) ? TTS_START_CAP : run_r.pulse_count;

    // Transmit and start levels, registered together so they rise together
    always_comb begin
        tx_p_nxt  = 1'b0;
        start_nxt = 1'b0;
        if (state_r == TTS_TX) begin
            tx_p_nxt = (per_cnt_r < half);
            if (run_r.shift_en && pulse_r >= run_r.shift_pos) begin
                tx_p_nxt = ~tx_p_nxt;
            end
            start_nxt = (pulse_r < start_len);
        end
    end

    // Transducer drive outputs; damping reverses the final pulse
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            tx_p_o    <= 1'b0;
            tx_n_o    <= 1'b0;
            tx_damp_o <= 1'b0;
            start_o   <= 1'b0;
        end else begin
            tx_damp_o <= (state_r == TTS_TX) && run_r.damp_en && last_pulse;
            if ((state_r == TTS_TX) && run_r.damp_en && last_pulse) begin
                tx_p_o <= ~tx_p_nxt;
                tx_n_o <= tx_p_nxt;
            end else begin
                tx_p_o <= tx_p_nxt;
                tx_n_o <= (state_r == TTS_TX) & ~tx_p_nxt;
            end
            start_o <= start_nxt;
        end
    end

    // Zero-cross level with hysteresis; rising wins over falling
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            zc_r   <= 1'b0;
            zc_d_r <= 1'b0;
        end else begin
            if (above_lvl) begin
                zc_r <= 1'b1;
            end else if (below_lvl) begin
                zc_r <= 1'b0;
            end
            zc_d_r <= zc_r;
        end
    end

    // Echo qualification: armed once the threshold is crossed in a window
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            qual_r <= 1'b0;
        end else if (state_r != TTS_RX) begin
            qual_r <= 1'b0;
        end else if (thld_lvl) begin
            qual_r <= 1'b1;
        end
    end

    // Stop output follows the qualified zero-cross level
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stop_o <= 1'b0;
        end else begin
            stop_o <= (state_r == TTS_RX) && qual_r && zc_r;
        end
    end

    // Counters for status: stops this run, runs since reset
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stops_r <= '0;
            runs_r  <= '0;
        end else begin
            if (state_r == TTS_IDLE && state_nxt != TTS_IDLE) begin
                stops_r <= '0;
                runs_r  <= runs_r + 8'h01;
            end else if (state_r == TTS_RX && qual_r && zc_r && !zc_d_r) begin
                stops_r <= stops_r + 8'h01;
            end
        end
    end

    // Busy flag for the controller
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (state_nxt != TTS_IDLE) | trig_ok | (pend_r & en_lvl);
        end
    end

endmodule : tts_sequencer

// [verilog/tts_pkg.sv]
package tts_pkg;

    // Register byte offsets on the bus
    localparam logic [3:0] TTS_CFG_OFS        = 4'h0;
    localparam logic [3:0] TTS_STAT_OFS       = 4'h4;

    // Configuration word field positions
    localparam int TTS_DIV_LSB                = 0;
    localparam int TTS_NUM_LSB                = 3;
    localparam int TTS_SHPOS_LSB              = 8;
    localparam int TTS_SHEN_BIT               = 13;
    localparam int TTS_DAMP_BIT               = 14;
    localparam int TTS_PROF_LSB               = 16;
    localparam int TTS_WIN_LSB                = 24;

    // Field widths
    localparam int TTS_DIV_W                  = 3;
    localparam int TTS_NUM_W                  = 5;
    localparam int TTS_PROF_W                 = 2;
    localparam int TTS_WIN_W                  = 8;

    // Reset values: divide select 2h, one pulse, profile 0, window 255 periods
    localparam logic [31:0] TTS_CFG_RST       = 32'hff00_000a;
    localparam logic [TTS_PROF_W-1:0] TTS_PROF_NONE = 2'h3;

    // Start pulse lasts at most this many transmit periods
    localparam logic [TTS_NUM_W-1:0] TTS_START_CAP = 5'h03;

    // Status word field positions
    localparam int TTS_ST_BUSY_BIT            = 0;
    localparam int TTS_ST_ZC_BIT              = 1;
    localparam int TTS_ST_QUAL_BIT            = 2;
    localparam int TTS_ST_STOPS_LSB           = 8;
    localparam int TTS_ST_RUNS_LSB            = 16;

    // Configuration carried as one unit
    typedef struct packed {
        logic [TTS_WIN_W-1:0]  rx_window;
        logic [TTS_PROF_W-1:0] profile;
        logic                  damp_en;
        logic                  shift_en;
        logic [TTS_NUM_W-1:0]  shift_pos;
        logic [TTS_NUM_W-1:0]  pulse_count;
        logic [TTS_DIV_W-1:0]  tx_divide_select;
    } tts_cfg_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        TTS_IDLE = 3'b001,
        TTS_TX   = 3'b010,
        TTS_RX   = 3'b100
    } tts_state_t;

endpackage : tts_pkg

// [verilog/tts_pin_sync.sv]
`timescale 1ns/1ps
// Three-stage pin synchroniser; the output level moves only once the
// second and third stages agree, which rejects a one-cycle glitch.
module tts_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Per-bit agreement filter
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_agree
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    level_o[g] <= 1'b0;
                end else if (s2_r[g] == s3_r[g]) begin
                    level_o[g] <= s3_r[g];
                end
            end
        end
    endgenerate

endmodule : tts_pin_sync

// [sim/tts_sequencer_sva.sv]
`timescale 1ns/1ps
module tts_seq_sva (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Pins
    input wire logic trigger_i,
    input wire logic start_o,
    input wire logic tx_p_o,
    input wire logic tx_n_o,
    input wire logic tx_damp_o,
    input wire logic stop_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Start rises seen in the current run, saturating at two
    logic       start_q_r;
    logic [1:0] starts_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_q_r <= 1'b0;
            starts_r  <= 2'h0;
        end else begin
            start_q_r <= start_o;
            if (!busy_o) starts_r <= 2'h0;
            else if (start_o && !start_q_r && starts_r != 2'h2) starts_r <= starts_r + 2'h1;
        end
    end

    property p_start_busy; $rose(start_o) |-> busy_o; endproperty
    a_start_busy: assert property (p_start_busy) else $error("start outside a run");
    property p_start_tx; $rose(start_o) |-> $rose(tx_p_o); endproperty
    a_start_tx: assert property (p_start_tx) else $error("burst not aligned to start");
    property p_one_start; starts_r <= 2'h1; endproperty
    a_one_start: assert property (p_one_start) else $error("second start in one run");
    property p_trig_cause; $rose(busy_o) |-> trigger_i; endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("run without trigger");
    property p_idle_quiet; !busy_o |-> !start_o && !tx_p_o && !tx_n_o; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
    property p_start_end; $fell(start_o) |-> busy_o; endproperty
    a_start_end: assert property (p_start_end) else $error("start ended after run");
    property p_stop_run; stop_o |-> busy_o; endproperty
    a_stop_run: assert property (p_stop_run) else $error("stop outside a run");
    property p_damp_run; tx_damp_o |-> busy_o; endproperty
    a_damp_run: assert property (p_damp_run) else $error("damping outside a run");
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
endmodule : tts_seq_sva

bind tts_sequencer tts_seq_sva u_tts_seq_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .trigger_i(trigger_i), .start_o(start_o), .tx_p_o(tx_p_o),
    .tx_n_o(tx_n_o), .tx_damp_o(tx_damp_o), .stop_o(stop_o), .busy_o(busy_o));

// [sim/tts_far_model.sv]
`timescale 1ns/1ps
module tts_far_model (
    // Clock, reset, pins
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        enable_i,
    input  wire logic        busy_i,
    input  wire logic        start_i,
    input  wire logic        tx_p_i,
    input  wire logic        tx_damp_i,
    // Bench requests
    input  wire logic        trig_req_i,
    input  wire logic [15:0] period_i,
    output logic             ref_clk_o = 1'b0,
    output logic             trigger_o = 1'b0
);
    int   cyc = 0, t0 = 0, en_cnt = 0, rst_cnt = 0, starts = 0, start_len = 0, rises = 0, o, h;
    logic start_q = 1'b0, tx_q = 1'b0, damp_seen = 1'b0;
    logic samp [32];
    logic [1:0] div_r = 2'h0;

    // Reference clock of 6.25 MHz, kept well under the sampling limit
    always @(posedge clk_i) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) ref_clk_o <= !ref_clk_o;
    end

    // Timing observer; statistics cleared by a request while idle
    always @(posedge clk_i) begin
        cyc     <= cyc + 1;
        rst_cnt <= reset_n_i ? rst_cnt + 1 : 0;
        en_cnt  <= enable_i ? en_cnt + 1 : 0;
        start_q <= start_i;
        tx_q    <= tx_p_i;
        h = period_i / 2;
        o = cyc - t0;
        if (trig_req_i && !busy_i) begin
            starts    <= 0;
            start_len <= 0;
            rises     <= 0;
            damp_seen <= 1'b0;
        end else begin
            if (start_i && !start_q) t0 <= cyc;
            if (start_i && !start_q) starts <= starts + 1;
            if (start_i) start_len <= start_len + 1;
            if (tx_p_i && !tx_q) rises <= rises + 1;
            if (tx_damp_i) damp_seen <= 1'b1;
            if (starts != 0 && o % h == h / 2 && o / h < 32) samp[o / h] <= tx_p_i;
        end
    end

    // Trigger only after enable and reset waits, held long enough to sync
    always @(posedge trig_req_i) begin
        while (en_cnt < 3 || rst_cnt < 160) @(posedge clk_i);
        trigger_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        trigger_o <= 1'b0;
    end
endmodule : tts_far_model

// [sim/tts_sequencer_bench.sv]
`timescale 1ns/1ps
module tts_sequencer_bench;
    import tts_pkg::*;
    logic        clk_i = 0, reset_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, enable_i = 0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, trigger_i, ref_clk, tx_p_o, tx_n_o, tx_damp_o, start_o, stop_o, busy_o;
    logic        echo_above_ref_i = 0, echo_below_hyst_i = 0, echo_over_thld_i = 0, trig_req = 0;
    logic [15:0] period = 16'h10;
    int          err_count = 0, n_compared = 0;

    tts_sequencer u_tts_sequencer (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enable_i(enable_i),
        .trigger_i(trigger_i), .reference_clock_input_i(ref_clk), .echo_above_ref_i(echo_above_ref_i),
        .echo_below_hyst_i(echo_below_hyst_i), .echo_over_thld_i(echo_over_thld_i), .tx_p_o(tx_p_o),
        .tx_n_o(tx_n_o), .tx_damp_o(tx_damp_o), .start_o(start_o), .stop_o(stop_o), .busy_o(busy_o));
    tts_far_model u_tts_far_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
        .busy_i(busy_o), .start_i(start_o), .tx_p_i(tx_p_o), .tx_damp_i(tx_damp_o),
        .trig_req_i(trig_req), .period_i(period), .ref_clk_o(ref_clk), .trigger_o(trigger_i));

    always #10 clk_i = !clk_i;

    task automatic summarize;
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Classic cycle: held until ack is sampled, then released for a cycle
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int t;
        t = 0;
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= s;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 50);
        q = wb_dat_o;
        check("ack", 1, wb_ack_o);
        wb_cyc_i <= 0; wb_stb_i <= 0;
        @(posedge clk_i);
    endtask : wb

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
        wb(0, a, 32'h0, 4'hf);
        check(nm, e & m, q & m);
    endtask : rd

    function automatic logic [31:0] mk(input int dv, n, sp, se, dm, pf, wn);
        mk = (32'(wn) << TTS_WIN_LSB) | (32'(pf) << TTS_PROF_LSB) | (32'(dm) << TTS_DAMP_BIT)
           | (32'(se) << TTS_SHEN_BIT) | (32'(sp) << TTS_SHPOS_LSB) | (32'(n) << TTS_NUM_LSB) | 32'(dv);
    endfunction : mk

    task automatic fire;
        int t;
        t = 0;
        trig_req <= 1;
        @(posedge clk_i);
        trig_req <= 0;
        while (busy_o !== 1'b1 && t++ < 200) @(posedge clk_i);
    endtask : fire

    // One burst with a retrigger while busy; period in clocks is 8 << (div + 1)
    task automatic run(input int dv, n, sp, se, dm);
        int t, p;
        logic e;
        t = 0;
        p = 8 << (dv + 1);
        period <= 16'(p);
        wb(1, TTS_CFG_OFS, mk(dv, n, sp, se, dm, 0, 1), 4'hf);
        fire();
        check("busy", 1, busy_o);
        repeat (14) @(posedge clk_i);
        fire();
        while (busy_o !== 1'b0 && t++ < 3000) @(posedge clk_i);
        check("run_done", 0, busy_o);
        repeat (30) @(posedge clk_i);
        check("starts", n > 0, u_tts_far_model.starts);
        check("start_len", (n > 3 ? 3 : n) * p, u_tts_far_model.start_len);
        check("pulses", n, u_tts_far_model.rises);
        check("damped", dm, u_tts_far_model.damp_seen);
        for (int j = 0; j < 2 * n; j++) begin
            e = !j[0] ^ ((se != 0 && j / 2 >= sp) || (dm != 0 && j / 2 == n - 1));
            check("tx_half", e, u_tts_far_model.samp[j]);
        end
    endtask : run

    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        summarize();
    end

    initial begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1;
        repeat (10) @(posedge clk_i);
        rd(TTS_CFG_OFS, TTS_CFG_RST, 32'hffffffff, "cfg_reset");
        rd(TTS_STAT_OFS, 32'h0, 32'hffffffff, "stat_reset");
        rd(4'h8, 32'h0, 32'hffffffff, "unmapped");
        wb(1, TTS_STAT_OFS, 32'hffffffff, 4'hf);
        rd(TTS_STAT_OFS, 32'h0, 32'hffffffff, "stat_ro");
        wb(1, TTS_CFG_OFS, 32'hffffffff, 4'h1);
        rd(TTS_CFG_OFS, 32'hff0000ff, 32'hffffffff, "cfg_lane");
        enable_i <= 1;
        // Profile none must block a run
        wb(1, TTS_CFG_OFS, mk(0, 1, 0, 0, 0, 3, 1), 4'hf);
        fire();
        check("prof_block", 0, busy_o);
        run(0, 1, 0, 0, 0);
        run(1, 2, 0, 0, 0);
        run(0, 4, 2, 1, 0);
        run(0, 5, 0, 0, 1);
        run(2, 3, 0, 0, 0);
        run(0, 0, 0, 0, 0);
        // Echo with hysteresis during a long receive window
        wb(1, TTS_CFG_OFS, mk(0, 1, 0, 0, 0, 0, 60), 4'hf);
        fire();
        repeat (40) @(posedge clk_i);
        echo_over_thld_i <= 1;
        for (int i = 0; i < 3; i++) begin
            echo_above_ref_i <= 1;
            echo_below_hyst_i <= 0;
            repeat (8) @(posedge clk_i);
            check("stop", 1, stop_o);
            echo_above_ref_i <= 0;
            repeat (8) @(posedge clk_i);
            rd(TTS_STAT_OFS, 32'h2, 32'h2, "zc_hold");
            echo_below_hyst_i <= 1;
            repeat (8) @(posedge clk_i);
            rd(TTS_STAT_OFS, 32'h0, 32'h2, "zc_clear");
        end
        echo_over_thld_i <= 0;
        echo_below_hyst_i <= 0;
        repeat (1100) @(posedge clk_i);
        rd(TTS_STAT_OFS, 32'h0007_0300, 32'h00ff_ff01, "stops_runs");
        summarize();
    end
endmodule : tts_sequencer_bench
